// [eti_timer.sv]
// Purpose: event timer with comparators, line routing and message writes
// Assumes: config inputs are synchronous and held by software
// Notes:   write pulses act for one cycle each
//
// How it works
// - legacy select: t0 to 0/2, t1 to 8
// - legacy select still allows message writes
// - per timer route field, capability readable
// - timers 0,1 use apic lines 20-23 only
// - timer 2: line 11 both, 20-23 apic
// - timer 3: line 12 both, 20-23 apic
// - timers 4-7 deliver only by message
// - software uses edge mode for messages
// - message writes payload to target address
// - message enable suppresses line outputs
// - one-shot fires on every counter match
// - one-shot comparator changed only by software
// - direct write loads comparator halves directly
// - timer 0 32 or 64 bit, others 32
// - software keeps periods at least 5 us
// - all timers support one-shot
// - periodic match adds last written value
// - periodic read shows next match point
// - only timer 0 periodic, capability readable
// - software uses level mode when sharing
// - legacy controller lines driven active high
// - overall enable gates all interrupts
// - counter counts every clock while enabled
module eti_timer
    import eti_pkg::*;
#(
    parameter int NUM_TIMERS = ETI_NUM_TIMERS
) (
    input  wire logic                    sys_clk_in,
    input  wire logic                    resetn_in,
    eti_link_if.dev                      link,
    input  wire logic [1:0]              gen_cfg_in,
    input  wire logic [7:0]              int_enable_in,
    input  wire logic [7:0]              level_mode_in,
    input  wire logic [7:0]              periodic_in,
    input  wire logic                    mode64_in,
    input  wire logic [7:0]              msg_delivery_enable_in,
    input  wire logic [7:0][4:0]         irq_route_select_in,
    input  wire logic [7:0][31:0]        msg_target_address_in,
    input  wire logic [7:0][31:0]        msg_payload_value_in,
    input  wire logic [7:0]              comparator_direct_write_in,
    input  wire logic                    cmp_wr_in,
    input  wire logic [2:0]              wr_timer_in,
    input  wire logic                    wr_hi_in,
    input  wire logic [31:0]             wr_data_in,
    input  wire logic                    cnt_wr_in,
    input  wire logic [7:0]              int_clear_in,
    input  wire logic [2:0]              rd_timer_in,
    output logic      [63:0]             counter_out,
    output logic      [63:0]             cmp_rd_data_out,
    output logic      [31:0]             route_cap_out,
    output logic                         periodic_cap_out,
    output logic      [7:0]              int_status_out
);

    initial begin
        if (NUM_TIMERS != ETI_NUM_TIMERS) begin
            $error("eti_timer supports exactly eight timers");
        end
    end

    // ========================================================
    // routing decode
    function automatic logic [39:0] route_vec(input int t,
                                              input logic [4:0] sel,
                                              input logic legacy);
        logic [31:0] one;
        logic [39:0] v;
        one = 32'h1 << sel;
        v   = '0;
        if (legacy && t == 0) begin
            v[ETI_LEG_T0_PIC]       = 1'b1;
            v[16 + ETI_LEG_T0_APIC] = 1'b1;
        end else if (legacy && t == 1) begin
            v[ETI_LEG_T1_PIC]       = 1'b1;
            v[16 + ETI_LEG_T1_APIC] = 1'b1;
        end else if ((one & ETI_ROUTE_CAP[t]) != '0) begin
            v[16 +: 24] = one[23:0];
            v[15:0]     = one[15:0] & ETI_PIC_OK_MASK[15:0];
        end
        return v;
    endfunction : route_vec

    // ========================================================
    // state
    logic [63:0]       cnt,       next_cnt;
    logic [7:0][63:0]  cmp,       next_cmp;
    logic [7:0][63:0]  period,    next_period;
    logic [7:0]        val_set,   next_val_set;
    logic [7:0]        status,    next_status;
    logic [7:0]        edge_q,    next_edge_q;
    logic [7:0]        pending,   next_pending;
    eti_msg_state_e    mstate,    next_mstate;
    logic              mvalid,    next_mvalid;
    logic [31:0]       maddr,     next_maddr;
    logic [31:0]       mdata,     next_mdata;
    logic [15:0]       pic,       next_pic;
    logic [23:0]       apic,      next_apic;
    logic              legacy_q,  next_legacy_q;
    logic [63:0]       rd_cmp,    next_rd_cmp;
    logic [31:0]       rd_cap,    next_rd_cap;
    logic              rd_per,    next_rd_per;

    logic              en;
    logic              legacy;
    logic [7:0]        fire;
    logic [7:0]        grant;

    assign en     = gen_cfg_in[ETI_ENABLE_BIT];
    assign legacy = gen_cfg_in[ETI_LEGACY_BIT];

    // ========================================================
    // next state
    always_comb begin
        logic        wide;
        logic        per;
        logic        hit;
        logic        line;
        logic [39:0] rv;
        next_cnt     = cnt;
        next_cmp     = cmp;
        next_period  = period;
        next_val_set = val_set | comparator_direct_write_in;
        fire         = '0;
        grant        = '0;
        next_pic     = '0;
        next_apic    = '0;
        wide         = 1'b0;
        per          = 1'b0;
        hit          = 1'b0;
        line         = 1'b0;
        rv           = '0;
        if (en) begin
            next_cnt = cnt + 64'h1;
        end
        if (cnt_wr_in) begin
            if (wr_hi_in) begin
                next_cnt[63:32] = wr_data_in;
            end else begin
                next_cnt[31:0] = wr_data_in;
            end
        end
        for (int t = 0; t < ETI_NUM_TIMERS; t++) begin
            wide = ETI_WIDE_CAP[t] && mode64_in;
            per  = ETI_PERIODIC_CAP[t] && periodic_in[t];
            hit  = wide ? (cnt == cmp[t]) : (cnt[31:0] == cmp[t][31:0]);
            fire[t] = en && hit && int_enable_in[t];
            if (en && hit && per) begin
                next_cmp[t] = cmp[t] + period[t];
                if (!wide) begin
                    next_cmp[t][63:32] = '0;
                end
            end
            // one-shot comparator only changes below
            if (cmp_wr_in && wr_timer_in == 3'(t)
                    && (wide || !wr_hi_in)) begin
                if (wr_hi_in) begin
                    next_period[t][63:32] = wr_data_in;
                end else begin
                    next_period[t][31:0] = wr_data_in;
                end
                if (!per || val_set[t]) begin
                    if (wr_hi_in) begin
                        next_cmp[t][63:32] = wr_data_in;
                    end else begin
                        next_cmp[t][31:0] = wr_data_in;
                    end
                end
                next_val_set[t] = comparator_direct_write_in[t];
            end
            line = en && int_enable_in[t] && !msg_delivery_enable_in[t]
                && (level_mode_in[t] ? status[t] : edge_q[t]);
            rv = route_vec(t, irq_route_select_in[t], legacy);
            if (line) begin
                next_pic  = next_pic | rv[15:0];
                next_apic = next_apic | rv[39:16];
            end
        end
        // set wins over clear
        next_status  = (status & ~int_clear_in) | fire;
        next_edge_q  = fire & ~level_mode_in & ~msg_delivery_enable_in;
        next_legacy_q = legacy;
        // message delivery
        next_mstate  = mstate;
        next_mvalid  = mvalid;
        next_maddr   = maddr;
        next_mdata   = mdata;
        unique case (mstate)
            ETI_MSG_IDLE: begin
                for (int t = ETI_NUM_TIMERS - 1; t >= 0; t--) begin
                    if (en && pending[t]) begin
                        grant = 8'h1 << t;
                    end
                end
                for (int t = 0; t < ETI_NUM_TIMERS; t++) begin
                    if (grant[t]) begin
                        next_maddr = msg_target_address_in[t];
                        next_mdata = msg_payload_value_in[t];
                    end
                end
                if (grant != '0) begin
                    next_mvalid = 1'b1;
                    next_mstate = ETI_MSG_SEND;
                end
            end
            ETI_MSG_SEND: begin
                if (link.msg_ready) begin
                    next_mvalid = 1'b0;
                    next_mstate = ETI_MSG_IDLE;
                end
            end
        endcase
        next_pending = (pending & ~grant) | (fire & msg_delivery_enable_in);
        next_rd_cmp  = cmp[rd_timer_in];
        next_rd_cap  = ETI_ROUTE_CAP[rd_timer_in];
        next_rd_per  = ETI_PERIODIC_CAP[rd_timer_in];
    end

    // ========================================================
    // registers
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt      <= ETI_CNT_RST;
            cmp      <= {ETI_NUM_TIMERS{ETI_CMP_RST}};
            period   <= {ETI_NUM_TIMERS{ETI_CMP_RST}};
            val_set  <= '0;
            status   <= '0;
            edge_q   <= '0;
            pending  <= '0;
            mstate   <= ETI_MSG_IDLE;
            mvalid   <= 1'b0;
            maddr    <= '0;
            mdata    <= '0;
            pic      <= '0;
            apic     <= '0;
            legacy_q <= 1'b0;
            rd_cmp   <= '0;
            rd_cap   <= '0;
            rd_per   <= 1'b0;
        end else begin
            cnt      <= next_cnt;
            cmp      <= next_cmp;
            period   <= next_period;
            val_set  <= next_val_set;
            status   <= next_status;
            edge_q   <= next_edge_q;
            pending  <= next_pending;
            mstate   <= next_mstate;
            mvalid   <= next_mvalid;
            maddr    <= next_maddr;
            mdata    <= next_mdata;
            pic      <= next_pic;
            apic     <= next_apic;
            legacy_q <= next_legacy_q;
            rd_cmp   <= next_rd_cmp;
            rd_cap   <= next_rd_cap;
            rd_per   <= next_rd_per;
        end
    end

    // ========================================================
    // outputs
    assign link.pic_line  = pic;
    assign link.apic_line = apic;
    assign link.pit_block = legacy_q;
    assign link.rtc_block = legacy_q;
    assign link.msg_valid = mvalid;
    assign link.msg_addr  = maddr;
    assign link.msg_data  = mdata;
    assign counter_out      = cnt;
    assign cmp_rd_data_out  = rd_cmp;
    assign route_cap_out    = rd_cap;
    assign periodic_cap_out = rd_per;
    assign int_status_out   = status;

endmodule : eti_timer

// [eti_pkg.sv]
// Purpose: shared constants for the event timer interrupt routing block
// Assumes: 20 MHz system clock, eight timers on one main counter
// Notes:   capability tables are fixed by the hardware
package eti_pkg;

    // ========================================================
    // sizes
    localparam int ETI_NUM_TIMERS = 8;
    localparam int ETI_PIC_LINES  = 16;
    localparam int ETI_APIC_LINES = 24;
    localparam int ETI_ROUTE_W    = 5;

    // ========================================================
    // general configuration word
    localparam logic [7:0] ETI_GEN_CFG_OFS = 8'h10;
    localparam int         ETI_ENABLE_BIT  = 0;
    localparam int         ETI_LEGACY_BIT  = 1;

    // ========================================================
    // legacy replacement line numbers
    localparam int ETI_LEG_T0_PIC  = 0;
    localparam int ETI_LEG_T0_APIC = 2;
    localparam int ETI_LEG_T1_PIC  = 8;
    localparam int ETI_LEG_T1_APIC = 8;

    // ========================================================
    // capabilities, one entry per timer (index 0 rightmost)
    localparam logic [7:0][31:0] ETI_ROUTE_CAP = {
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h00f0_1000, 32'h00f0_0800, 32'h00f0_0000, 32'h00f0_0000};
    localparam logic [31:0] ETI_PIC_OK_MASK  = 32'h0000_ffff;
    localparam logic [7:0]  ETI_PERIODIC_CAP = 8'h01;
    localparam logic [7:0]  ETI_WIDE_CAP     = 8'h01;

    // ========================================================
    // reset values
    localparam logic [63:0] ETI_CNT_RST = 64'h0000_0000_0000_0000;
    localparam logic [63:0] ETI_CMP_RST = 64'hffff_ffff_ffff_ffff;

    // ========================================================
    // timing
    localparam int ETI_CLK_PERIOD_NS  = 50;
    localparam int ETI_MIN_PERIOD_NS  = 5000;
    localparam int ETI_MIN_PERIOD_CYC =
        (ETI_MIN_PERIOD_NS + ETI_CLK_PERIOD_NS - 1) / ETI_CLK_PERIOD_NS;

    typedef enum logic {ETI_MSG_IDLE, ETI_MSG_SEND} eti_msg_state_e;

endpackage : eti_pkg

// [eti_link_if.sv]
// Purpose: link between the timer block and the interrupt controllers
// Assumes: one clock shared by both ends
// Notes:   all lines active high
interface eti_link_if;
    logic [15:0] pic_line;
    logic [23:0] apic_line;
    logic        pit_block;
    logic        rtc_block;
    logic        msg_valid;
    logic [31:0] msg_addr;
    logic [31:0] msg_data;
    logic        msg_ready;

    modport dev (
        output pic_line, apic_line, pit_block, rtc_block,
        output msg_valid, msg_addr, msg_data,
        input  msg_ready
    );
    modport ctl (
        input  pic_line, apic_line, pit_block, rtc_block,
        input  msg_valid, msg_addr, msg_data,
        output msg_ready
    );
endinterface : eti_link_if

// [eti_irq_ctl.sv]
// Purpose: far end: legacy controller, apic lines and message sink
// Assumes: one clock shared with the timer block
// Notes:   legacy sources are blocked while the timer replaces them
module eti_irq_ctl
    import eti_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        resetn_in,
    eti_link_if.ctl          link,
    input  wire logic        pit_irq_in,
    input  wire logic        rtc_irq_in,
    input  wire logic        msg_hold_in,
    output logic      [15:0] pic_irq_out,
    output logic      [23:0] apic_irq_out,
    output logic             msg_seen_out,
    output logic      [31:0] msg_addr_out,
    output logic      [31:0] msg_data_out
);

    logic [15:0] pic,   next_pic;
    logic [23:0] apic,  next_apic;
    logic        seen,  next_seen;
    logic [31:0] addr,  next_addr;
    logic [31:0] data,  next_data;
    logic        ready, next_ready;

    // ========================================================
    // next state
    always_comb begin
        next_pic  = link.pic_line;
        next_apic = link.apic_line;
        if (!link.pit_block) begin
            next_pic[ETI_LEG_T0_PIC]   = link.pic_line[ETI_LEG_T0_PIC]
                                         | pit_irq_in;
            next_apic[ETI_LEG_T0_APIC] = link.apic_line[ETI_LEG_T0_APIC]
                                         | pit_irq_in;
        end
        if (!link.rtc_block) begin
            next_pic[ETI_LEG_T1_PIC]   = link.pic_line[ETI_LEG_T1_PIC]
                                         | rtc_irq_in;
            next_apic[ETI_LEG_T1_APIC] = link.apic_line[ETI_LEG_T1_APIC]
                                         | rtc_irq_in;
        end
        next_seen  = link.msg_valid && ready;
        next_addr  = addr;
        next_data  = data;
        if (link.msg_valid && ready) begin
            next_addr = link.msg_addr;
            next_data = link.msg_data;
        end
        next_ready = !msg_hold_in && !(link.msg_valid && ready);
    end

    // ========================================================
    // registers
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pic   <= '0;
            apic  <= '0;
            seen  <= 1'b0;
            addr  <= '0;
            data  <= '0;
            ready <= 1'b0;
        end else begin
            pic   <= next_pic;
            apic  <= next_apic;
            seen  <= next_seen;
            addr  <= next_addr;
            data  <= next_data;
            ready <= next_ready;
        end
    end

    assign link.msg_ready = ready;
    assign pic_irq_out    = pic;
    assign apic_irq_out   = apic;
    assign msg_seen_out   = seen;
    assign msg_addr_out   = addr;
    assign msg_data_out   = data;

endmodule : eti_irq_ctl

// [eti_link_monitor.sv]
// Purpose: wire checks on the timer to controller link
// Assumes: one clock, asynchronous active-low reset
// Notes:   sees only the link signals
module eti_link_monitor (
    input  wire logic        sys_clk_in,
    input  wire logic        resetn_in,
    input  wire logic [15:0] pic_line,
    input  wire logic [23:0] apic_line,
    input  wire logic        pit_block,
    input  wire logic        rtc_block,
    input  wire logic        msg_valid,
    input  wire logic [31:0] msg_addr,
    input  wire logic [31:0] msg_data,
    input  wire logic        msg_ready
);
    timeunit 1ns;
    timeprecision 1ns;

    // ========================================
    // assertions
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);

    a_msg_held_valid: assert property (
        msg_valid && !msg_ready |=> msg_valid)
        else $error("message withdrawn before accept");
    a_msg_held_data: assert property (
        msg_valid && !msg_ready |=> $stable(msg_addr) && $stable(msg_data))
        else $error("message address or data moved while waiting");
    a_msg_one_at: assert property (
        msg_valid && msg_ready |=> !msg_valid)
        else $error("message valid stays after accept");
    a_pic_legal_lines: assert property (
        (pic_line & 16'he6fe) == 16'h0)
        else $error("legacy line outside the allowed set");
    a_apic_legal_lines: assert property (
        (apic_line & 24'h0fe6fb) == 24'h0)
        else $error("apic line outside the allowed set");
    a_block_pair: assert property (pit_block == rtc_block)
        else $error("legacy source blocks disagree");
    a_t0_legacy_pair: assert property (
        pic_line[0] == apic_line[2])
        else $error("timer 0 legacy lines disagree");
    a_t1_legacy_pair: assert property (
        pic_line[8] == apic_line[8])
        else $error("timer 1 legacy lines disagree");

    // ========================================
    // cover
    c_msg_accept: cover property (msg_valid && msg_ready);
    c_legacy_t0: cover property (pic_line[0]);
    c_apic_high: cover property (|apic_line[23:20]);
endmodule : eti_link_monitor

// [tb.sv]
// Purpose: self-checking bench for timer block and controller end
// Assumes: 20 MHz clock, edge mode only
// Notes:   expected events queued, a watcher pops them
module tb
    import eti_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ========================================
    // signals
    logic             sys_clk_in, resetn_in, m64, cmp_wr, wr_hi, cnt_wr;
    logic             pit, rtc, hold, per_cap, seen;
    logic [1:0]       gen_cfg;
    logic [2:0]       wr_t, rd_t, tt;
    logic [4:0]       rr;
    logic [7:0]       int_en, lvl, per, msg_en, dw, clr, st_o;
    logic [31:0]      wd, cap_o, sa, sd, cc;
    logic [63:0]      cnt_o, cmp_o, v0;
    logic [15:0]      pic_o;
    logic [23:0]      apic_o;
    logic [39:0]      lv_q;
    logic [7:0][4:0]  route;
    logic [7:0][31:0] maddr, mdata;
    logic [39:0]      lq[$];
    logic [63:0]      mq[$];
    int               n_mismatch, checked, n_ev, cyc;
    logic [31:0]      caps[8] = '{32'h00f00000, 32'h00f00000,
        32'h00f00800, 32'h00f01000, 32'h0, 32'h0, 32'h0, 32'h0};

    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    // ========================================
    // design
    eti_link_if link_if ();
    eti_timer u_eti_timer (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .link(link_if), .gen_cfg_in(gen_cfg), .int_enable_in(int_en),
        .level_mode_in(lvl), .periodic_in(per), .mode64_in(m64),
        .msg_delivery_enable_in(msg_en), .irq_route_select_in(route),
        .msg_target_address_in(maddr), .msg_payload_value_in(mdata),
        .comparator_direct_write_in(dw), .cmp_wr_in(cmp_wr),
        .wr_timer_in(wr_t), .wr_hi_in(wr_hi), .wr_data_in(wd),
        .cnt_wr_in(cnt_wr), .int_clear_in(clr), .rd_timer_in(rd_t),
        .counter_out(cnt_o), .cmp_rd_data_out(cmp_o),
        .route_cap_out(cap_o), .periodic_cap_out(per_cap),
        .int_status_out(st_o));
    eti_irq_ctl u_eti_irq_ctl (.sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in), .link(link_if), .pit_irq_in(pit),
        .rtc_irq_in(rtc), .msg_hold_in(hold), .pic_irq_out(pic_o),
        .apic_irq_out(apic_o), .msg_seen_out(seen), .msg_addr_out(sa),
        .msg_data_out(sd));
    eti_link_monitor u_eti_link_monitor (.sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in), .pic_line(link_if.pic_line),
        .apic_line(link_if.apic_line), .pit_block(link_if.pit_block),
        .rtc_block(link_if.rtc_block), .msg_valid(link_if.msg_valid),
        .msg_addr(link_if.msg_addr), .msg_data(link_if.msg_data),
        .msg_ready(link_if.msg_ready));

    // ========================================
    // tasks
    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] s);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #5;
    endtask : tick

    task automatic wr(input logic c, input logic [2:0] t, input logic h,
                      input logic [31:0] d);
        cnt_wr = c;
        cmp_wr = !c;
        wr_t = t;
        wr_hi = h;
        wd = d;
        tick(1);
        {cnt_wr, cmp_wr} = 2'b00;
        tick(1);
    endtask : wr

    task automatic arm(input int t);
        dw[t] = 1'b1;
        tick(1);
        dw = '0;
    endtask : arm

    task automatic run(input logic [2:0] t, input logic [31:0] c,
                       input logic [39:0] e);
        int tgt;
        gen_cfg[0] = 1'b0;
        wr(1'b1, 3'd0, 1'b0, 32'h0);
        wr(1'b1, 3'd0, 1'b1, 32'h0);
        tgt = n_ev + 1;
        if (e !== '0) lq.push_back(e);
        gen_cfg[0] = 1'b1;
        int_en = 8'h1 << t;
        wr(1'b0, t, 1'b0, c);
        for (int i = 0; i < 300 && n_ev < tgt; i++) tick(1);
        chk("event", 64'(tgt), 64'(n_ev));
        gen_cfg[0] = 1'b0;
        rd_t = t;
        tick(2);
    endtask : run

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask : done

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // ========================================
    // watcher and timeout
    always @(posedge sys_clk_in) begin
        if ({link_if.pic_line, link_if.apic_line} !== '0 && lv_q === '0) begin
            chk("line", lq.size() ? lq.pop_front() : '0,
                {link_if.pic_line, link_if.apic_line});
            n_ev++;
        end
        if (seen === 1'b1) begin
            chk("msg", mq.size() ? mq.pop_front() : '0, {sa, sd});
            n_ev++;
        end
        lv_q <= {link_if.pic_line, link_if.apic_line};
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    always @(posedge sys_clk_in) #5 hold = 1'($urandom % 2);

    // ========================================
    // tests
    initial begin
        void'($urandom(62));
        {gen_cfg, int_en, lvl, per, m64, msg_en, dw, clr} = '0;
        {cmp_wr, cnt_wr, wr_t, wr_hi, wd, rd_t, pit, rtc, hold} = '0;
        {route, maddr, mdata, lv_q, resetn_in} = '0;
        {n_mismatch, checked, n_ev, cyc} = '0;
        tick(20);
        resetn_in = 1'b1;
        tick(1);
        for (int t = 0; t < 8; t++) begin
            rd_t = 3'(t);
            tick(2);
            chk("cap", 64'(caps[t]), 64'(cap_o));
            chk("per_cap", 64'(t == 0), 64'(per_cap));
        end
        done("caps");
        gen_cfg = 2'b01;
        tick(1);
        v0 = cnt_o;
        tick(10);
        chk("count", v0 + 64'd10, cnt_o);
        gen_cfg = 2'b00;
        tick(2);
        v0 = cnt_o;
        tick(10);
        chk("hold", v0, cnt_o);
        done("counter");
        gen_cfg[1] = 1'b1;
        run(3'd0, 32'd20, {16'h0001, 24'h000004});
        run(3'd1, 32'd25, {16'h0100, 24'h000100});
        msg_en[0] = 1'b1;
        maddr[0] = $urandom;
        mdata[0] = $urandom;
        mq.push_back({maddr[0], mdata[0]});
        run(3'd0, 32'd30, '0);
        msg_en = '0;
        {pit, rtc} = 2'b11;
        tick(3);
        chk("blocked", 64'h0, {pic_o[0], pic_o[8], apic_o[2]});
        chk("pit_block", 64'h1, link_if.pit_block);
        gen_cfg[1] = 1'b0;
        tick(3);
        chk("unblocked", 64'h7, {pic_o[0], pic_o[8], apic_o[2]});
        {pit, rtc} = 2'b00;
        done("legacy");
        for (int i = 0; i < 6; i++) begin
            tt = 3'($urandom % 4);
            rr = 5'(20 + $urandom % 4);
            cc = 20 + $urandom % 40;
            route[tt] = rr;
            run(tt, cc, {16'h0, 24'h1 << rr});
            chk("oneshot", 64'(cc), 64'(cmp_o[31:0]));
        end
        done("routing");
        for (int t = 4; t < 8; t++) begin
            msg_en[t] = 1'b1;
            maddr[t] = $urandom;
            mdata[t] = $urandom;
            mq.push_back({maddr[t], mdata[t]});
            run(3'(t), 32'(20 + t), '0);
        end
        msg_en = '0;
        done("message");
        per = 8'h01;
        route[0] = 5'd21;
        arm(0);
        run(3'd0, 32'd30, {16'h0, 24'h200000});
        chk("next", 64'd60, 64'(cmp_o[31:0]));
        per = '0;
        m64 = 1'b1;
        rd_t = 3'd0;
        arm(0);
        wr(1'b0, 3'd0, 1'b0, 32'h5);
        arm(0);
        wr(1'b0, 3'd0, 1'b1, 32'h1);
        tick(2);
        chk("cmp64", 64'h1_0000_0005, cmp_o);
        done("periodic");
        print_verdict();
    end
endmodule : tb
